// *** logic/power_mode_pkg.sv ***
`default_nettype none
package power_mode_pkg;
	// clock
	localparam int CLK_MHZ = 100;

	// register offsets
	localparam logic [7:0] REG_PWR_CTRL = 8'h00;
	localparam logic [7:0] REG_PORT_DOWN = 8'h01;
	localparam logic [7:0] REG_EEE_EN = 8'h02;
	localparam logic [7:0] REG_IDLE_TMO_LO = 8'h03;
	localparam logic [7:0] REG_IDLE_TMO_HI = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h05;
	localparam logic [7:0] REG_EEE_ACTIVE = 8'h06;
	localparam logic [7:0] REG_STRAPS = 8'h07;

	// field positions
	localparam int MODE_LSB = 3;
	localparam int MODE_MSB = 4;
	localparam int STAT_NORMAL = 0;
	localparam int STAT_ENERGY = 1;
	localparam int STAT_SOFT_DOWN = 2;
	localparam int STAT_LOW_POWER = 3;

	// mode field codes
	localparam logic [1:0] CODE_NORMAL = 2'h0;
	localparam logic [1:0] CODE_ENERGY = 2'h1;
	localparam logic [1:0] CODE_SOFT_DOWN = 2'h2;

	// values after reset
	localparam logic [1:0] MODE_FIELD_RST = 2'h0;
	localparam logic [4:0] PORT_DOWN_RST = 5'h00;
	localparam logic [3:0] EEE_EN_RST = 4'h0;
	localparam logic [15:0] IDLE_TMO_RST = 16'h05DC;

	// sizes
	localparam int PORT_COUNT = 5;
	localparam int PHY_PORTS = 4;
	localparam int STRAP_WIDTH = 8;

	// times and derived cycle counts
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ + 999) / 1000;
	localparam int ENERGY_PERSIST_NS = 100;
	localparam int ENERGY_PERSIST_CYCLES = (ENERGY_PERSIST_NS * CLK_MHZ + 999) / 1000;
	localparam int LINK_PULSE_NS = 100;
	localparam int LINK_PULSE_CYCLES = (LINK_PULSE_NS * CLK_MHZ) / 1000;

	typedef enum logic [2:0] {
		GM_NORMAL = 3'b001,
		GM_ENERGY = 3'b010,
		GM_SOFT_DOWN = 3'b100
	} global_mode_t;

	typedef enum logic [1:0] {
		ED_NORMAL_PWR = 2'b01,
		ED_LOW_PWR = 2'b10
	} ed_state_t;

	// spare code falls back to normal
	function automatic global_mode_t decode_mode(input logic [1:0] code);
		case (code)
			CODE_ENERGY: decode_mode = GM_ENERGY;
			CODE_SOFT_DOWN: decode_mode = GM_SOFT_DOWN;
			default: decode_mode = GM_NORMAL;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** logic/ed_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface ed_link_if;
	logic enable;
	logic energy;
	logic tick;
	logic [15:0] timeoutUs;
	logic lowPower;
	logic linkPulse;
	modport ctrl(output enable, output energy, output tick, output timeoutUs,
		input lowPower, input linkPulse);
	modport fsm(input enable, input energy, input tick, input timeoutUs,
		output lowPower, output linkPulse);
endinterface
`default_nettype wire

// *** logic/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin_sync width must be at least one");
		end
	endgenerate

	// meta is read only by stable
	always_comb begin
		d.meta = pinIn;
		d.stable = q.meta;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign pinOut = q.stable;
endmodule
`default_nettype wire

// *** logic/energy_detect_fsm.sv ***
`timescale 1ns/1ns
`default_nettype none
module energy_detect_fsm #(
	parameter int PULSE_INTERVAL_US = 16000
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// link to the controller
	ed_link_if.fsm link
);
	typedef struct packed {
		power_mode_pkg::ed_state_t state;
		logic [15:0] idleUs;
		logic [7:0] persist;
		logic [15:0] intervalUs;
		logic [7:0] pulseCnt;
		logic lowPower;
		logic linkPulse;
	} ed_fsm_t;

	localparam logic [7:0] PERSIST_LAST = 8'(power_mode_pkg::ENERGY_PERSIST_CYCLES);
	localparam logic [7:0] PULSE_LEN = 8'(power_mode_pkg::LINK_PULSE_CYCLES);
	localparam logic [15:0] INTERVAL_LAST = 16'(PULSE_INTERVAL_US - 1);

	ed_fsm_t q;
	ed_fsm_t d;

	generate
		if (PULSE_INTERVAL_US < 2 || PULSE_INTERVAL_US > 65536) begin : g_bad_interval
			$error("link pulse interval out of range");
		end
	endgenerate

	always_comb begin
		d = q;
		if (q.pulseCnt != 8'h00) begin
			d.pulseCnt = q.pulseCnt - 8'h01;
		end
		if (!link.enable) begin
			d.state = power_mode_pkg::ED_NORMAL_PWR;
			d.idleUs = 16'h0000;
			d.persist = 8'h00;
			d.intervalUs = 16'h0000;
			d.pulseCnt = 8'h00;
		end else begin
			case (q.state)
				power_mode_pkg::ED_NORMAL_PWR: begin
					if (link.energy) begin
						d.idleUs = 16'h0000;
					end else if (link.tick) begin
						if (q.idleUs > link.timeoutUs) begin
							d.state = power_mode_pkg::ED_LOW_PWR;
							d.intervalUs = 16'h0000;
							d.persist = 8'h00;
						end else if (q.idleUs != 16'hFFFF) begin
							d.idleUs = q.idleUs + 16'h0001;
						end
					end
				end
				power_mode_pkg::ED_LOW_PWR: begin
					// short glitches restart the persistence count
					if (!link.energy) begin
						d.persist = 8'h00;
					end else if (q.persist >= PERSIST_LAST) begin
						d.state = power_mode_pkg::ED_NORMAL_PWR;
						d.persist = 8'h00;
						d.idleUs = 16'h0000;
						d.pulseCnt = 8'h00;
					end else begin
						d.persist = q.persist + 8'h01;
					end
					if (link.tick && d.state == power_mode_pkg::ED_LOW_PWR) begin
						if (q.intervalUs >= INTERVAL_LAST) begin
							d.intervalUs = 16'h0000;
							d.pulseCnt = PULSE_LEN;
						end else begin
							d.intervalUs = q.intervalUs + 16'h0001;
						end
					end
				end
				default: begin
					d.state = power_mode_pkg::ED_NORMAL_PWR;
				end
			endcase
		end
		d.lowPower = (d.state == power_mode_pkg::ED_LOW_PWR);
		d.linkPulse = d.lowPower && (d.pulseCnt != 8'h00);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{state: power_mode_pkg::ED_NORMAL_PWR, default: '0};
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign link.lowPower = q.lowPower;
	assign link.linkPulse = q.linkPulse;
endmodule
`default_nettype wire

// *** logic/power_mode_controller.sv ***
// Contract
// - exactly one global power mode at once
// - starts in normal mode after power-up
// - mode field code 00 selects normal
// - mode field code 01 selects energy-detect
// - normal keeps clocks, PHYs, MACs, management on
// - energy-detect stops PLL, MACs, host interface
// - soft power-down leaves only management interface
// - idle longer than timeout enters low power
// - low power keeps only receive energy detect
// - low power sends sparse link pulses
// - energy beyond 100ns returns to normal power
// - leaving soft power-down restores defaults, resamples straps
// - per-port power-down independent of global mode
// - EEE only when enabled and partner agreed
// - port five never offers EEE
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller #(
	parameter int PULSE_INTERVAL_US = 16000
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// pins
	input wire logic [3:0] energyPin,
	input wire logic [7:0] strapPin,
	// auto-negotiation result
	input wire logic [3:0] eeeAgreed,
	// power gates
	output logic pllClkEn,
	output logic [3:0] phyPowerEn,
	output logic [3:0] phyEnergyDetectOnly,
	output logic [4:0] macEn,
	output logic hostIfEn,
	output logic mgmtIfEn,
	output logic linkPulseOut,
	output logic [3:0] eeeActive,
	// configuration
	output logic [7:0] strapValue,
	output logic regDefaultsPulse
);
	typedef struct packed {
		logic [1:0] modeField;
		power_mode_pkg::global_mode_t mode;
		logic [4:0] portDown;
		logic [3:0] eeeEn;
		logic [15:0] timeoutUs;
		logic [7:0] straps;
		logic strapPending;
		logic [1:0] syncAge;
		logic [7:0] rdData;
		logic [6:0] tickCnt;
		logic tick;
		logic pllClkEn;
		logic [3:0] phyPowerEn;
		logic [3:0] phyEdOnly;
		logic [4:0] macEn;
		logic hostIfEn;
		logic mgmtIfEn;
		logic [3:0] eeeActive;
		logic linkPulse;
		logic regDefaults;
	} ctrl_state_t;

	localparam logic [6:0] TICK_LAST = 7'(power_mode_pkg::TICK_CYCLES - 1);

	localparam ctrl_state_t CTRL_RESET = '{
		modeField: power_mode_pkg::MODE_FIELD_RST,
		mode: power_mode_pkg::GM_NORMAL,
		portDown: power_mode_pkg::PORT_DOWN_RST,
		eeeEn: power_mode_pkg::EEE_EN_RST,
		timeoutUs: power_mode_pkg::IDLE_TMO_RST,
		straps: 8'h00,
		strapPending: 1'b1,
		syncAge: 2'h0,
		rdData: 8'h00,
		tickCnt: 7'h00,
		tick: 1'b0,
		pllClkEn: 1'b1,
		phyPowerEn: 4'hF,
		phyEdOnly: 4'h0,
		macEn: 5'h1F,
		hostIfEn: 1'b1,
		mgmtIfEn: 1'b1,
		eeeActive: 4'h0,
		linkPulse: 1'b0,
		regDefaults: 1'b0
	};

	ctrl_state_t q;
	ctrl_state_t d;
	logic [3:0] energySync;
	logic [7:0] strapSync;
	power_mode_pkg::global_mode_t nextMode;
	logic isNormal;
	logic isEnergy;

	ed_link_if edl();

	generate
		if (power_mode_pkg::TICK_CYCLES < 2 || power_mode_pkg::TICK_CYCLES > 128) begin : g_bad_tick
			$error("microsecond prescaler does not fit its counter");
		end
		if (power_mode_pkg::ENERGY_PERSIST_CYCLES > 255) begin : g_bad_persist
			$error("energy persistence count does not fit its counter");
		end
	endgenerate

	pin_sync #(
		.WIDTH(power_mode_pkg::PHY_PORTS)
	) u_energy_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.pinIn(energyPin),
		.pinOut(energySync)
	);

	pin_sync #(
		.WIDTH(power_mode_pkg::STRAP_WIDTH)
	) u_strap_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.pinIn(strapPin),
		.pinOut(strapSync)
	);

	energy_detect_fsm #(
		.PULSE_INTERVAL_US(PULSE_INTERVAL_US)
	) u_energy_fsm (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.link(edl)
	);

	// a powered-down port cannot wake the device
	assign edl.enable = (q.mode == power_mode_pkg::GM_ENERGY);
	assign edl.energy = |(energySync & ~q.portDown[3:0]);
	assign edl.tick = q.tick;
	assign edl.timeoutUs = q.timeoutUs;

	always_comb begin
		d = q;
		d.regDefaults = 1'b0;
		d.rdData = 8'h00;
		nextMode = q.mode;
		isNormal = 1'b0;
		isEnergy = 1'b0;

		// microsecond time base for idle timeout and pulse spacing
		if (q.tickCnt >= TICK_LAST) begin
			d.tickCnt = 7'h00;
			d.tick = 1'b1;
		end else begin
			d.tickCnt = q.tickCnt + 7'h01;
			d.tick = 1'b0;
		end

		// synchroniser shows its reset value for two edges after release, so wait
		if (q.syncAge != 2'h2) begin
			d.syncAge = q.syncAge + 2'h1;
		end
		if (q.strapPending && q.syncAge == 2'h2) begin
			d.straps = strapSync;
			d.strapPending = 1'b0;
		end

		// outside normal only the mode field stays writable, so the host can return
		if (regWrEn) begin
			case (regAddr)
				power_mode_pkg::REG_PWR_CTRL: begin
					d.modeField = regWrData[power_mode_pkg::MODE_MSB:power_mode_pkg::MODE_LSB];
				end
				power_mode_pkg::REG_PORT_DOWN: begin
					if (q.mode == power_mode_pkg::GM_NORMAL) begin
						d.portDown = regWrData[4:0];
					end
				end
				power_mode_pkg::REG_EEE_EN: begin
					// no bit exists for port five
					if (q.mode == power_mode_pkg::GM_NORMAL) begin
						d.eeeEn = regWrData[3:0];
					end
				end
				power_mode_pkg::REG_IDLE_TMO_LO: begin
					if (q.mode == power_mode_pkg::GM_NORMAL) begin
						d.timeoutUs[7:0] = regWrData;
					end
				end
				power_mode_pkg::REG_IDLE_TMO_HI: begin
					if (q.mode == power_mode_pkg::GM_NORMAL) begin
						d.timeoutUs[15:8] = regWrData;
					end
				end
				default: begin
				end
			endcase
		end

		nextMode = power_mode_pkg::decode_mode(d.modeField);

		// leaving soft power-down: defaults back, straps sampled again
		if (q.mode == power_mode_pkg::GM_SOFT_DOWN && nextMode != power_mode_pkg::GM_SOFT_DOWN) begin
			d.modeField = power_mode_pkg::MODE_FIELD_RST;
			d.portDown = power_mode_pkg::PORT_DOWN_RST;
			d.eeeEn = power_mode_pkg::EEE_EN_RST;
			d.timeoutUs = power_mode_pkg::IDLE_TMO_RST;
			d.strapPending = 1'b1;
			d.regDefaults = 1'b1;
			nextMode = power_mode_pkg::GM_NORMAL;
		end

		// one-hot state holds a single mode
		d.mode = nextMode;
		isNormal = (nextMode == power_mode_pkg::GM_NORMAL);
		isEnergy = (nextMode == power_mode_pkg::GM_ENERGY);

		d.pllClkEn = isNormal;
		d.hostIfEn = isNormal;
		d.mgmtIfEn = 1'b1;
		for (int i = 0; i < power_mode_pkg::PHY_PORTS; i++) begin
			// energy-detect normal-power keeps the PHY up so a link can form
			d.phyPowerEn[i] = !d.portDown[i] &&
				(isNormal || (isEnergy && !edl.lowPower));
			d.phyEdOnly[i] = !d.portDown[i] && isEnergy;
			d.eeeActive[i] = isNormal && !d.portDown[i] &&
				d.eeeEn[i] && eeeAgreed[i];
		end
		for (int i = 0; i < power_mode_pkg::PORT_COUNT; i++) begin
			d.macEn[i] = isNormal && !d.portDown[i];
		end
		d.linkPulse = isEnergy && edl.linkPulse;

		// reads answer in every mode; unmapped offsets read zero
		if (regRdEn) begin
			case (regAddr)
				power_mode_pkg::REG_PWR_CTRL: begin
					d.rdData[power_mode_pkg::MODE_MSB:power_mode_pkg::MODE_LSB] = q.modeField;
				end
				power_mode_pkg::REG_PORT_DOWN: begin
					d.rdData[4:0] = q.portDown;
				end
				power_mode_pkg::REG_EEE_EN: begin
					d.rdData[3:0] = q.eeeEn;
				end
				power_mode_pkg::REG_IDLE_TMO_LO: begin
					d.rdData = q.timeoutUs[7:0];
				end
				power_mode_pkg::REG_IDLE_TMO_HI: begin
					d.rdData = q.timeoutUs[15:8];
				end
				power_mode_pkg::REG_STATUS: begin
					d.rdData[power_mode_pkg::STAT_NORMAL] = (q.mode == power_mode_pkg::GM_NORMAL);
					d.rdData[power_mode_pkg::STAT_ENERGY] = (q.mode == power_mode_pkg::GM_ENERGY);
					d.rdData[power_mode_pkg::STAT_SOFT_DOWN] =
						(q.mode == power_mode_pkg::GM_SOFT_DOWN);
					d.rdData[power_mode_pkg::STAT_LOW_POWER] = edl.lowPower;
				end
				power_mode_pkg::REG_EEE_ACTIVE: begin
					d.rdData[3:0] = q.eeeActive;
				end
				power_mode_pkg::REG_STRAPS: begin
					d.rdData = q.straps;
				end
				default: begin
					d.rdData = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= CTRL_RESET;
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign regRdData = q.rdData;
	assign pllClkEn = q.pllClkEn;
	assign phyPowerEn = q.phyPowerEn;
	assign phyEnergyDetectOnly = q.phyEdOnly;
	assign macEn = q.macEn;
	assign hostIfEn = q.hostIfEn;
	assign mgmtIfEn = q.mgmtIfEn;
	assign linkPulseOut = q.linkPulse;
	assign eeeActive = q.eeeActive;
	assign strapValue = q.straps;
	assign regDefaultsPulse = q.regDefaults;
endmodule
`default_nettype wire

// *** verification/power_mode_controller_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic [3:0] eeeAgreed,
	// gates
	input wire logic pllClkEn,
	input wire logic [3:0] phyPowerEn,
	input wire logic [3:0] phyEnergyDetectOnly,
	input wire logic [4:0] macEn,
	input wire logic hostIfEn,
	input wire logic mgmtIfEn,
	input wire logic linkPulseOut,
	input wire logic [3:0] eeeActive,
	input wire logic regDefaultsPulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic modeWr;
	logic [3:0] pulseRun;
	assign modeWr = clkEn && regWrEn && regAddr == power_mode_pkg::REG_PWR_CTRL;

	// counts high cycles of the pulse; a long repetition would unroll badly
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pulseRun <= 4'h0;
		end else if (clkEn) begin
			if (!linkPulseOut) begin
				pulseRun <= 4'h0;
			end else if (pulseRun != 4'hF) begin
				pulseRun <= pulseRun + 4'h1;
			end
		end
	end

	property p_mgmt_on; mgmtIfEn; endproperty
	a_mgmt_on: assert property (p_mgmt_on) else $error("management off");
	// pll and host run together only in normal mode
	property p_one_mode; pllClkEn == hostIfEn && (!pllClkEn || phyEnergyDetectOnly == 4'h0);
	endproperty
	a_one_mode: assert property (p_one_mode) else $error("mixed mode gates");
	property p_macs_off; !pllClkEn |-> macEn == 5'h00; endproperty
	a_macs_off: assert property (p_macs_off) else $error("mac on without pll");
	property p_pulse_gate; linkPulseOut |-> phyPowerEn == 4'h0 && !pllClkEn; endproperty
	a_pulse_gate: assert property (p_pulse_gate) else $error("pulse outside low power");
	// a wake or mode change may cut a pulse, so only one ending in low power is timed
	property p_pulse_len; $fell(linkPulseOut) && phyPowerEn == 4'h0 &&
		phyEnergyDetectOnly != 4'h0 |-> pulseRun == 4'hA; endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
	property p_pulse_max; linkPulseOut |-> pulseRun < 4'hA; endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
	property p_eee; (eeeActive & ~$past(eeeAgreed)) == 4'h0; endproperty
	a_eee: assert property (p_eee) else $error("eee without agreement");
	property p_defaults; regDefaultsPulse |=> !regDefaultsPulse && pllClkEn; endproperty
	a_defaults: assert property (p_defaults) else $error("defaults pulse wrong");
	property p_wr_energy; modeWr && regWrData[4:3] == power_mode_pkg::CODE_ENERGY && pllClkEn
		|=> !pllClkEn && !hostIfEn && macEn == 5'h00; endproperty
	a_wr_energy: assert property (p_wr_energy) else $error("energy mode not entered");
	property p_wr_normal; modeWr && regWrData[4:3] == power_mode_pkg::CODE_NORMAL
		|=> pllClkEn && hostIfEn; endproperty
	a_wr_normal: assert property (p_wr_normal) else $error("normal mode not entered");
endmodule

bind power_mode_controller power_mode_controller_props power_mode_controller_props_inst (
	.sys_clk, .reset_n, .clkEn, .regAddr, .regWrData, .regWrEn, .eeeAgreed, .pllClkEn,
	.phyPowerEn, .phyEnergyDetectOnly, .macEn, .hostIfEn, .mgmtIfEn, .linkPulseOut,
	.eeeActive, .regDefaultsPulse
);
`default_nettype wire

// *** verification/test_power_mode_controller.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_power_mode_controller;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [3:0] energyPin = 4'h0;
	logic [7:0] strapPin = 8'hA5;
	logic [3:0] eeeAgreed = 4'h0;
	logic [7:0] regRdData, strapValue;
	logic [3:0] phyPowerEn, phyEnergyDetectOnly, eeeActive;
	logic [4:0] macEn;
	logic pllClkEn, hostIfEn, mgmtIfEn, linkPulseOut, regDefaultsPulse;
	int mismatches = 0;
	int tests_run = 0;
	int n;

	always #5 sys_clk = ~sys_clk;

	// short pulse interval keeps the low-power phase brief
	power_mode_controller #(.PULSE_INTERVAL_US(4)) power_mode_controller_inst (
		.sys_clk, .reset_n, .clkEn, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
		.energyPin, .strapPin, .eeeAgreed, .pllClkEn, .phyPowerEn, .phyEnergyDetectOnly,
		.macEn, .hostIfEn, .mgmtIfEn, .linkPulseOut, .eeeActive, .strapValue, .regDefaultsPulse
	);

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic limit(input int lim);
		if (n >= lim) begin
			mismatches++;
			$display("MISMATCH wait expected done seen timeout");
			report_and_stop;
		end
	endtask

	// sample after the edge so flop updates have landed
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1;
		check(what, regRdData, exp);
	endtask

	task automatic t_reset;
		check("pllClkEn", pllClkEn, 1'b1);
		check("phyPowerEn", phyPowerEn, 4'hF);
		check("macEn", macEn, 5'h1F);
		check("hostIfEn", hostIfEn, 1'b1);
		rd(power_mode_pkg::REG_STATUS, 8'h01, "status");
		rd(8'h3F, 8'h00, "unmapped");
		check("strapValue", strapValue, 8'hA5);
		$display("test reset done");
	endtask

	task automatic t_modes;
		wr(power_mode_pkg::REG_PORT_DOWN, 8'h03);
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h08);
		check("pllClkEn", pllClkEn, 1'b0);
		check("macEn", macEn, 5'h00);
		check("edOnly", phyEnergyDetectOnly, 4'hC);
		rd(power_mode_pkg::REG_STATUS, 8'h02, "status");
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h00);
		rd(power_mode_pkg::REG_STATUS, 8'h01, "status");
		check("phyPowerEn", phyPowerEn, 4'hC);
		check("macEn", macEn, 5'h1C);
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h10);
		check("phyPowerEn", phyPowerEn, 4'h0);
		rd(power_mode_pkg::REG_STATUS, 8'h04, "status");
		@(posedge sys_clk);
		strapPin <= 8'h3C;
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h18);
		repeat (3) tick;
		check("strapValue", strapValue, 8'h3C);
		rd(power_mode_pkg::REG_PORT_DOWN, 8'h00, "portDown");
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h18);
		rd(power_mode_pkg::REG_STATUS, 8'h01, "status");
		$display("test modes done");
	endtask

	task automatic t_eee;
		@(posedge sys_clk);
		eeeAgreed <= 4'h5;
		wr(power_mode_pkg::REG_EEE_EN, 8'hFF);
		rd(power_mode_pkg::REG_EEE_EN, 8'h0F, "eeeEn");
		check("eeeActive", eeeActive, 4'h5);
		wr(power_mode_pkg::REG_EEE_EN, 8'h03);
		rd(power_mode_pkg::REG_EEE_ACTIVE, 8'h01, "eeeActive");
		@(posedge sys_clk);
		eeeAgreed <= 4'h0;
		repeat (2) tick;
		check("eeeActive", eeeActive, 4'h0);
		$display("test eee done");
	endtask

	task automatic t_energy;
		wr(power_mode_pkg::REG_IDLE_TMO_LO, 8'h02);
		wr(power_mode_pkg::REG_IDLE_TMO_HI, 8'h00);
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h08); // mode field code 01 selects energy-detect
		for (n = 0; n < 1000 && phyPowerEn !== 4'h0; n++)
			tick;
		limit(1000);
		check("idleWait", n >= 200 && n <= 500, 1'b1);
		rd(power_mode_pkg::REG_STATUS, 8'h0A, "status");
		check("edOnly", phyEnergyDetectOnly, 4'hF);
		for (n = 0; n < 1000 && linkPulseOut !== 1'b1; n++)
			tick;
		limit(1000);
		for (n = 0; n < 20 && linkPulseOut === 1'b1; n++)
			tick;
		check("pulseLen", 8'(n), 8'h0A);
		// a burst shorter than 100ns must not wake the ports
		@(posedge sys_clk);
		energyPin <= 4'h1;
		repeat (8) @(posedge sys_clk);
		energyPin <= 4'h0;
		repeat (20) tick;
		check("phyPowerEn", phyPowerEn, 4'h0);
		@(posedge sys_clk);
		energyPin <= 4'h1;
		for (n = 0; n < 40 && phyPowerEn === 4'h0; n++)
			tick;
		limit(40);
		check("wakeCycles", n >= 11 && n <= 16, 1'b1);
		check("pllClkEn", pllClkEn, 1'b0);
		wr(power_mode_pkg::REG_PWR_CTRL, 8'h00);
		@(posedge sys_clk);
		energyPin <= 4'h0;
		$display("test energy done");
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		tick;
		t_reset;
		t_modes;
		t_eee;
		t_energy;
		report_and_stop;
	end
endmodule
`default_nettype wire
